/* adc_pkg.sv */
// constants and types shared by the converter control and its result queue
// assumes a 125 MHz system clock; all times below are converted to cycles
package adc_pkg;

   localparam int CLK_PERIOD_NS = 8;

   // result format: straight binary, one lsb is the reference over 256
   localparam int RES_BITS  = 8;
   localparam int LSB_STEPS = 256;

   // power-up from the low-current state, a least time: round up
   localparam int PWRUP_NS     = 1500;
   localparam int PWRUP_CYCLES = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // conversion time, bounded by the 5 us maximum: round down
   localparam int CONV_NS      = 4000;
   localparam int CONV_CYCLES  = CONV_NS / CLK_PERIOD_NS;
   localparam int STEP_CYCLES  = CONV_CYCLES / RES_BITS;

   localparam int TIMER_W = 10;
   localparam int BITCNT_W = 4;

   localparam logic [RES_BITS-1:0] RESULT_RESET = 8'h00;
   localparam logic [BITCNT_W-1:0] SERIAL_BITS  = 4'h8;

   // result queue between the converter and the output shift register
   localparam int FIFO_WIDTH = RES_BITS;
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [1:0] {
      st_off,
      st_power_up,
      st_ready,
      st_convert
   } conv_state_e;

   // trial code for one successive-approximation step
   function automatic logic [RES_BITS-1:0] sar_trial(
      input logic [RES_BITS-1:0] kept,
      input logic [2:0]          bit_idx
   );
      logic [RES_BITS-1:0] one;
      one = 8'h01;
      sar_trial = kept | (one << bit_idx);
   endfunction

endpackage

/* result_fifo.sv */
// result queue: flip-flop storage, valid and ready on both sides
// assumes both sides run on the same clock; push and pop may coincide
`timescale 1ns/1ns
`default_nettype none

module result_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,       // system clock
   input  wire logic             rst_b,     // async reset, active low
   input  wire logic             in_valid,  // producer offers a word
   output logic                  in_ready,  // queue can take a word
   input  wire logic [WIDTH-1:0] in_data,   // word offered
   output logic                  out_valid, // queue holds a word
   input  wire logic             out_ready, // consumer takes the word
   output logic      [WIDTH-1:0] out_data   // oldest word
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_idx;
   logic [AW-1:0]    rd_idx;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_idx];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_idx] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
         end
         if (pop) begin
            rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

/* adc_ctrl.sv */
// control of an 8-bit successive-approximation converter with serial readout
// assumes an analog comparator on the system clock and a host that drives
// the convert-start and serial clock pins asynchronously
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1: result is straight binary, one lsb equals reference divided by 256.
// R2: after power-on the block sits powered down and never converts.
// R3: convert-start rising edge powers up, complete 1.5 us later.
// R4: host holds convert-start low while supply is first applied.
// R5: convert-start falling edge ends tracking, holds input, starts conversion.
// R6: end of conversion latches result and samples convert-start; high stays up.
// R7: host raises convert-start within 3 us of conversion start.
// R8: convert-start still low at end of conversion powers down after latching.
// R9: conversion takes at most 5 us from the falling edge.
// R10: early falling edge waits for internal power-up timing, then converts.
// R11: rising edge enables the serial port; no shifting before it.
// R12: rising edge clears bit counter; extra clocks ignored; re-armed after eighth. Code disarms after the eighth until the next rising edge.
// R13: each bit driven on serial clock rising edges after the enable.
// R14: data output released on falling edge of eighth serial clock.
// R15: read before conversion end gives old result, after gives new.
// R16: new result waits for a read in progress to finish.
// R17: serial port works while the converter is powered down.
// R18: host waits 5 us after falling edge to read the current result.
// R19: host keeps reads from spanning a convert-start rising edge.
// R20: serial clock may be free-running or gated.
// R21: host may use convert-start as chip select between devices.
// R22: host on the opposite edge must invert the serial clock.
// R23: end of conversion returns the input to tracking.
// R24: bits go out most significant first, one per rising edge.
// R25: conversion timing runs from an internal timebase, not serial clock.
module adc_ctrl (
   input  wire logic                         clk,                // system clock
   input  wire logic                         rst_b,              // power-on reset
   input  wire logic                         conversion_start_n, // start pin
   input  wire logic                         serial_clk,         // host clock
   input  wire logic                         cmp_above,          // input >= dac
   output logic      [adc_pkg::RES_BITS-1:0] dac_code,           // trial level
   output logic                              track,              // sampling on
   output logic                              powered,            // core awake
   output logic                              data_out,           // serial data
   output logic                              data_out_oe_n       // 0 = driving
);
   import adc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, a change counts when two and three agree

   logic [1:0] sync1;
   logic [1:0] sync2;
   logic [1:0] sync3;
   logic [1:0] pin_level;
   logic       start_rise;
   logic       start_fall;
   logic       sclk_rise;
   logic       sclk_fall;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1 <= 2'h0;
         sync2 <= 2'h0;
         sync3 <= 2'h0;
      end else begin
         sync1 <= {serial_clk, conversion_start_n};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // level held until stages agree; reset low since the pin starts low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_level <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (sync2[i] == sync3[i]) begin
               pin_level[i] <= sync3[i];
            end
         end
      end
   end

   // an edge counts once stages two and three agree against the held level;
   // one decode for both pins keeps their latency identical
   function automatic logic pin_edge(
      input logic s2,
      input logic s3,
      input logic held,
      input logic rising
   );
      pin_edge = (s2 == s3) && (s3 == rising) && (held != rising);
   endfunction

   always_comb begin
      start_rise = pin_edge(sync2[0], sync3[0], pin_level[0], 1'b1);
      start_fall = pin_edge(sync2[0], sync3[0], pin_level[0], 1'b0);
      sclk_rise  = pin_edge(sync2[1], sync3[1], pin_level[1], 1'b1);
      sclk_fall  = pin_edge(sync2[1], sync3[1], pin_level[1], 1'b0);
   end

   ////////////////////////////////////////////////////////////////////////
   // power and conversion sequencing on the internal timebase

   conv_state_e             state;
   logic [TIMER_W-1:0]      timer;
   logic                    start_pending;
   logic [2:0]              bit_idx;
   logic [RES_BITS-1:0]     kept;
   logic                    result_valid;
   logic                    result_ready;
   logic                    step_done;
   logic                    conv_end;

   assign step_done = (timer == TIMER_W'(STEP_CYCLES - 1));
   assign conv_end  = (state == st_convert) && step_done && (bit_idx == 3'h0);

   // a full queue stalls the last step, so no result is ever dropped
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state         <= st_off;                                     // [R2]
         timer         <= '0;
         start_pending <= 1'b0;
      end else begin
         unique case (state)
            st_off: begin
               // falling edges here are ignored: nothing to convert with [R2]
               if (start_rise) begin
                  state         <= st_power_up;                       // [R3]
                  timer         <= '0;
                  start_pending <= 1'b0;
               end
            end
            st_power_up: begin
               if (start_fall) begin
                  start_pending <= 1'b1;                              // [R10]
               end
               if (timer == TIMER_W'(PWRUP_CYCLES - 1)) begin
                  timer <= '0;
                  if (start_pending || start_fall) begin
                     state <= st_convert;                             // [R10]
                  end else begin
                     state <= st_ready;
                  end
               end else begin
                  timer <= timer + 1'b1;
               end
            end
            st_ready: begin
               if (start_fall) begin
                  state <= st_convert;                                // [R5]
                  timer <= '0;
               end
            end
            st_convert: begin
               if (!step_done) begin
                  timer <= timer + 1'b1;                              // [R25]
               end else if (bit_idx != 3'h0) begin
                  timer <= '0;
               end else if (result_ready) begin
                  timer <= '0;
                  // pin level at the end decides the mode [R6] [R8]
                  state <= pin_level[0] ? st_ready : st_off;
               end
            end
         endcase
      end
   end

   // successive approximation, msb trial first, 8 steps of STEP_CYCLES each [R9]
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_idx <= 3'h7;
         kept    <= RESULT_RESET;
      end else if (state != st_convert) begin
         bit_idx <= 3'h7;
         kept    <= RESULT_RESET;
      end else if (step_done && bit_idx != 3'h0) begin
         if (cmp_above) begin
            kept <= sar_trial(kept, bit_idx);                         // [R1]
         end
         bit_idx <= bit_idx - 1'b1;
      end
   end

   // lsb decision folded in at the end; code = floor(vin * 256 / vref) [R1]
   assign result_valid = conv_end;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dac_code <= RESULT_RESET;
         track    <= 1'b1;
         powered  <= 1'b0;
      end else begin
         dac_code <= (state == st_convert) ? sar_trial(kept, bit_idx)
                                           : RESULT_RESET;
         // hold only while converting, tracking again after the end [R5] [R23]
         // a full queue keeps the hold until the last decision is taken
         track    <= (state != st_convert) || (conv_end && result_ready);
         powered  <= (state == st_ready) || (state == st_convert);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result queue

   logic [RES_BITS-1:0] final_code;
   logic                q_valid;
   logic                q_ready;
   logic [RES_BITS-1:0] q_data;

   assign final_code = cmp_above ? sar_trial(kept, 3'h0) : kept;

   result_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_result_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (result_valid),
      .in_ready  (result_ready),
      .in_data   (final_code),
      .out_valid (q_valid),
      .out_ready (q_ready),
      .out_data  (q_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // serial port, independent of power state [R17]

   logic [RES_BITS-1:0] shift_reg;
   logic [BITCNT_W-1:0] bit_cnt;
   logic                port_armed;
   logic                reading;
   logic                shift_step;
   logic                read_done;

   // a read is in progress from its first bit until the eighth falling edge
   assign reading    = (bit_cnt != '0);
   // loading waits for the read to end [R15] [R16]
   assign q_ready    = !reading;
   // clocks past the eighth bit are ignored [R12]
   assign shift_step = port_armed && sclk_rise && (bit_cnt != SERIAL_BITS);
   assign read_done  = sclk_fall && (bit_cnt == SERIAL_BITS);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_reg <= RESULT_RESET;
      end else if (q_valid && q_ready) begin
         shift_reg <= q_data;                                         // [R6]
      end
   end

   // works with free-running or gated clocks: only edges are counted [R20]
   // a start rise outranks a serial edge in the same cycle, so a read that
   // wrongly spans the rise restarts cleanly instead of half shifting
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         port_armed <= 1'b0;                                          // [R11]
      end else if (start_rise) begin
         port_armed <= 1'b1;                                          // [R11]
      end else if (read_done) begin
         // next read needs a new rising edge [R12]
         port_armed <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt <= '0;
      end else if (start_rise) begin
         bit_cnt <= '0;                                               // [R12]
      end else if (shift_step) begin
         bit_cnt <= bit_cnt + 1'b1;
      end else if (read_done) begin
         bit_cnt <= '0;                                               // [R12]
      end
   end

   // msb first, one bit per rising edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_out <= 1'b0;
      end else if (!start_rise && shift_step) begin
         data_out <= shift_reg[3'h7 - bit_cnt[2:0]];          // [R13] [R24]
      end
   end

   // driven from the first bit, released on the eighth falling edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_out_oe_n <= 1'b1;
      end else if (start_rise) begin
         data_out_oe_n <= 1'b1;
      end else if (shift_step) begin
         data_out_oe_n <= 1'b0;                                       // [R13]
      end else if (read_done) begin
         data_out_oe_n <= 1'b1;                                       // [R14]
      end
   end

endmodule

`default_nettype wire

/* adc_ctrl_asserts.sv */
// checker for the converter control: timing of power, tracking and serial port
// assumes pins are held for many clocks and serial half-periods exceed 4 clk
`timescale 1ns/1ns
`default_nettype none

module adc_ctrl_checker (
   input wire logic                         clk,                // system clock
   input wire logic                         rst_b,              // async reset
   input wire logic                         conversion_start_n, // start pin
   input wire logic                         serial_clk,         // host clock
   input wire logic                         cmp_above,          // comparator
   input wire logic [adc_pkg::RES_BITS-1:0] dac_code,           // trial level
   input wire logic                         track,              // sampling on
   input wire logic                         powered,            // core awake
   input wire logic                         data_out,           // serial data
   input wire logic                         data_out_oe_n       // 0 = driving
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   ////////////////////////////////////////////////////////////////////////////
   sequence pin_rise_off;
      $rose(conversion_start_n) && !powered;
   endsequence
   sequence conv_end_low;
      $rose(track) && !conversion_start_n && !$past(conversion_start_n, 8);
   endsequence
   sequence conv_end_high;
      $rose(track) && conversion_start_n && $past(conversion_start_n, 8);
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   chk_off_quiet: assert property (!powered && !$past(powered) |-> track)
      else $error("conversion while powered down");
   chk_dac_idle: assert property (track && $past(track) |-> dac_code == 8'h00)
      else $error("trial level not cleared while tracking");
   chk_powerup_time: assert property (pin_rise_off |-> ##[186:196] powered)
      else $error("power-up not complete in time");
   chk_track_hold: assert property ($fell(track) |-> ##[490:500] $rose(track))
      else $error("conversion length wrong");
   chk_fall_converts: assert property (
      $fell(conversion_start_n) && powered |-> ##[2:6] !track)
      else $error("falling edge did not start conversion");
   chk_auto_powerdown: assert property (conv_end_low |-> ##[0:2] !powered)
      else $error("no power-down after conversion");
   chk_stay_powered: assert property (conv_end_high |-> powered[*4])
      else $error("powered down with start pin high");
   chk_first_bit: assert property ($fell(data_out_oe_n) |-> serial_clk)
      else $error("output enabled away from serial clock rise");
   chk_release_fall: assert property ($rose(data_out_oe_n) |-> !serial_clk)
      else $error("output released away from serial clock fall");
   chk_data_on_high: assert property (
      !data_out_oe_n && $changed(data_out) |-> serial_clk)
      else $error("data changed while serial clock low");
endmodule

bind adc_ctrl adc_ctrl_checker i_adc_ctrl_checker (
   .clk(clk), .rst_b(rst_b), .conversion_start_n(conversion_start_n),
   .serial_clk(serial_clk), .cmp_above(cmp_above), .dac_code(dac_code),
   .track(track), .powered(powered), .data_out(data_out),
   .data_out_oe_n(data_out_oe_n)
);
`default_nettype wire

/* adc_host.sv */
// host model: drives convert-start and a gated 125 ns serial clock, reads data
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ns
`default_nettype none

module adc_host (
   input  wire logic clk,                // system clock
   output logic      conversion_start_n, // start pin, also chip select
   output logic      serial_clk,         // gated serial clock
   input  wire logic data_out,           // serial data
   input  wire logic data_out_oe_n       // 0 = device drives
);
   logic line;

   // released line has no pull: show the inverse so a stale bit cannot pass
   assign line = data_out_oe_n ? ~data_out : data_out;

   initial begin
      conversion_start_n = 1'b0; // low while supply comes up
      serial_clk         = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic set_start(input logic v); // bench keeps reads apart
      @(posedge clk);
      conversion_start_n <= v;
   endtask

   // sample during the high phase: device moves data on rises
   task automatic read_byte(output logic [7:0] b, output logic [7:0] oe_seen,
                            output logic oe_after);
      b = 8'h00;
      oe_seen = 8'h00;
      // let the start rise reach the port before the first clock
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         serial_clk <= 1'b1;
         #62;
         b = {b[6:0], line};
         oe_seen = {oe_seen[6:0], data_out_oe_n};
         serial_clk <= 1'b0;
         #63;
      end
      oe_after = data_out_oe_n;
      serial_clk <= 1'b1;
      #62;
      oe_after = oe_after & data_out_oe_n;
      serial_clk <= 1'b0;
      #63;
   endtask
endmodule
`default_nettype wire

/* test_adc_conversion_and_serial_readout.sv */
// testbench: power-down and high-speed conversions with serial readback
// assumes the host model for the pins and an ideal comparator on vin
`timescale 1ns/1ns
`default_nettype none

module test_adc_conversion_and_serial_readout;
   import adc_pkg::*;
   logic                     clk, rst_b, cmp_above, oe_after;
   wire logic                conversion_start_n, serial_clk, track, powered;
   wire logic                data_out, data_out_oe_n;
   wire logic [RES_BITS-1:0] dac_code;
   logic [RES_BITS-1:0]      vin, v, prev, got;
   logic [7:0]               oe_seen;
   int                       num_errors, n_tests;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   assign cmp_above = (vin >= dac_code);

   adc_ctrl i_adc_ctrl (.clk(clk), .rst_b(rst_b),
      .conversion_start_n(conversion_start_n), .serial_clk(serial_clk),
      .cmp_above(cmp_above), .dac_code(dac_code), .track(track),
      .powered(powered), .data_out(data_out), .data_out_oe_n(data_out_oe_n));
   adc_host i_adc_host (.clk(clk), .conversion_start_n(conversion_start_n),
      .serial_clk(serial_clk), .data_out(data_out),
      .data_out_oe_n(data_out_oe_n));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] sar_expect(input logic [7:0] a);
      logic [7:0] k, t;
      k = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         t = k | (8'h01 << i);
         if (t <= a) k = t;
      end
      return k;
   endfunction

   task automatic results();
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic do_read(input logic [7:0] exp);
      i_adc_host.read_byte(got, oe_seen, oe_after);
      check(got, exp);
      check(oe_seen, 8'h00);
      check({7'h00, oe_after}, 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      vin = 8'h00;
      num_errors = 0;
      n_tests = 0;
      void'($urandom(32'he61a));
      wait_clk(16);
      rst_b <= 1'b1;
      wait_clk(4);
      check(powered, 1'b0);
      i_adc_host.read_byte(got, oe_seen, oe_after);
      check(oe_seen, 8'hff);
      check(track, 1'b1);
      prev = RESULT_RESET;
      // power-down mode: even passes read early, odd ones pulse short
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 :
             (i == 2) ? 8'h7f : 8'($urandom);
         @(posedge clk) vin <= v;
         i_adc_host.set_start(1'b1);
         if (i % 2 == 0) begin
            do_read(prev);
            wait_clk(60);
         end else begin
            wait_clk(4 + $urandom_range(0, 150));
         end
         i_adc_host.set_start(1'b0);
         wait_clk(8);
         if (i % 2 == 0) check(track, 1'b0);
         wait_clk(820);
         check(powered, 1'b0);
         check(track, 1'b1);
         prev = sar_expect(v);
         if (i % 2 == 1) do_read(prev);
      end
      // high-speed mode: early read, then a read across the end
      v = 8'($urandom);
      @(posedge clk) vin <= v;
      i_adc_host.set_start(1'b1);
      wait_clk(250);
      check(powered, 1'b1);
      i_adc_host.set_start(1'b0);
      wait_clk(100);
      i_adc_host.set_start(1'b1);
      do_read(prev);
      wait_clk(500);
      check(powered, 1'b1);
      prev = sar_expect(v);
      v = 8'($urandom);
      @(posedge clk) vin <= v;
      i_adc_host.set_start(1'b0);
      wait_clk(100);
      i_adc_host.set_start(1'b1);
      wait_clk(300);
      do_read(prev);
      wait_clk(300);
      i_adc_host.set_start(1'b0);
      wait_clk(100);
      i_adc_host.set_start(1'b1);
      do_read(sar_expect(v));
      results();
   end

   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
